// ---- src/atxd_pkg.sv ----
// constants and types shared by the async transmit descriptor decoder
//
// Functional notes
// - header-immediate descriptor opcode is 4'h0
// - header-immediate key 3'h2 marks inline data
// - inline bytes start after sixteenth descriptor byte
// - header-immediate always advances pointer by 32
// - inline quadlets go into transmit FIFO
// - response context drops packet past deadline
// - cycle_a is seconds[2:0] then thirteen tick bits
// - header-immediate pushes at most four quadlets
// - final-buffer descriptor opcode is 4'h1
// - final-buffer key 3'h0 means memory buffer
// - final-buffer bytes read from buffer into FIFO
// - final-buffer completion marks end of packet
// - status bit set writes back status and time
// - interrupt field 11 always, 00 never
// - interrupt field 01 only on bad ack
// - status write-back uses context control [15:0]
// - next-block count zero ends list, else branch
package atxd_pkg;

    // ----------
    // register offsets and reset values
    // ----------
    localparam logic [11:0] ATXD_OFF_CTRL = 12'h000;
    localparam logic [11:0] ATXD_OFF_PTR = 12'h004;
    localparam logic [11:0] ATXD_OFF_STATUS = 12'h008;
    localparam logic [11:0] ATXD_OFF_CUR = 12'h00C;
    localparam logic [31:0] ATXD_RST_PTR = 32'h0000_0000;
    localparam int ATXD_CTRL_RUN = 0;
    localparam int ATXD_CTRL_RESP = 1;

    // context control low half, field positions
    localparam int ATXD_CCR_RUN = 15;
    localparam int ATXD_CCR_DEAD = 11;
    localparam int ATXD_CCR_ACTIVE = 10;
    localparam int ATXD_CCR_MISSED = 9;

    // ----------
    // descriptor layout
    // ----------
    localparam int ATXD_CMD_LO = 28;
    localparam int ATXD_S_BIT = 27;
    localparam int ATXD_KEY_LO = 24;
    localparam int ATXD_INT_LO = 20;
    localparam logic [3:0] ATXD_OP_MORE = 4'h0;
    localparam logic [3:0] ATXD_OP_LAST = 4'h1;
    localparam logic [2:0] ATXD_KEY_IMM = 3'h2;
    localparam logic [2:0] ATXD_KEY_BUF = 3'h0;
    localparam logic [1:0] ATXD_IRQ_ALWAYS = 2'b11;
    localparam logic [1:0] ATXD_IRQ_ON_ERR = 2'b01;
    localparam logic [31:0] ATXD_IMM_DATA_OFF = 32'h0000_0010;
    localparam logic [31:0] ATXD_IMM_DESC_SIZE = 32'h0000_0020;
    localparam logic [31:0] ATXD_STATUS_Q_OFF = 32'h0000_000C;
    localparam logic [15:0] ATXD_IMM_MAX_BYTES = 16'h0010;

    // ----------
    // acknowledge codes and cycle timer figures
    // ----------
    localparam logic [3:0] ATXD_ACK_NONE = 4'h0;
    localparam logic [3:0] ATXD_ACK_COMPLETE = 4'h1;
    localparam logic [3:0] ATXD_ACK_PENDING = 4'h2;
    localparam logic [16:0] ATXD_TICKS_PER_SEC = 17'h0_1F40;
    localparam logic [16:0] ATXD_TIME_WRAP = 17'h0_FA00;
    localparam logic [16:0] ATXD_TIME_HALF = 17'h0_7D00;

    // controller states
    typedef enum logic [8:0] {
        ATXD_ST_IDLE = 9'b0_0000_0001,
        ATXD_ST_FETCH = 9'b0_0000_0010,
        ATXD_ST_DECODE = 9'b0_0000_0100,
        ATXD_ST_READ = 9'b0_0000_1000,
        ATXD_ST_PUSH = 9'b0_0001_0000,
        ATXD_ST_ACK = 9'b0_0010_0000,
        ATXD_ST_WBACK = 9'b0_0100_0000,
        ATXD_ST_NEXT = 9'b0_1000_0000,
        ATXD_ST_HALT = 9'b1_0000_0000
    } atxd_state_t;

endpackage

// ---- src/atxd_deadline_chk.sv ----
// response deadline compare against the cycle timer
`timescale 1ns/10ps
`default_nettype none
module atxd_deadline_chk
    import atxd_pkg::*;
(
    // current time
    input wire logic [2:0] now_seconds,
    input wire logic [12:0] now_ticks,
    // deadline from the descriptor
    input wire logic [15:0] deadline,
    // result
    output logic expired
);
    logic [16:0] now_lin;
    logic [16:0] dl_lin;
    logic [16:0] diff;

    // linearise seconds and ticks; eight seconds wrap at 64000 ticks
    always_comb begin
        now_lin = 17'(now_seconds) * ATXD_TICKS_PER_SEC + 17'(now_ticks);
        dl_lin = 17'(deadline[15:13]) * ATXD_TICKS_PER_SEC
            + 17'(deadline[12:0]);
        if (now_lin >= dl_lin) begin
            diff = now_lin - dl_lin;
        end else begin
            diff = now_lin + ATXD_TIME_WRAP - dl_lin;
        end
        // past means within half the wrap after the deadline
        expired = (diff != 17'h0_0000) && (diff < ATXD_TIME_HALF);
    end
endmodule // atxd_deadline_chk
`default_nettype wire

// ---- src/atxd_irq_sel.sv ----
// completion interrupt decision from interrupt field and ack code
`timescale 1ns/10ps
`default_nettype none
module atxd_irq_sel
    import atxd_pkg::*;
(
    // descriptor interrupt field
    input wire logic [1:0] int_field,
    // acknowledge seen for the packet
    input wire logic [3:0] ack_code,
    // decision
    output logic fire
);
    logic bad_ack;

    // any ack other than complete or pending counts as a failure
    assign bad_ack = (ack_code != ATXD_ACK_COMPLETE)
        && (ack_code != ATXD_ACK_PENDING);
    assign fire = (int_field == ATXD_IRQ_ALWAYS)
        || ((int_field == ATXD_IRQ_ON_ERR) && bad_ack);
endmodule // atxd_irq_sel
`default_nettype wire

// ---- src/atxd_main.sv ----
// async transmit descriptor fetch, decode and execute engine
`timescale 1ns/10ps
`default_nettype none
module atxd_main
    import atxd_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic srst,
    input wire logic ce,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host memory master
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // cycle timer
    input wire logic [6:0] cycle_seconds_count,
    input wire logic [12:0] cycle_tick_count,
    // link acknowledge
    input wire logic ack_valid,
    input wire logic [3:0] ack_code,
    // transmit fifo
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [31:0] tx_data,
    output logic [2:0] tx_bytes,
    output logic tx_eop,
    // completion interrupt
    output logic context_irq
);
    // ----------
    // declarations
    // ----------
    atxd_state_t state_reg;
    atxd_state_t state_next;
    logic run_reg;
    logic resp_reg;
    logic dead_reg;
    logic missed_reg;
    logic drop_reg;
    logic [31:0] ptr_reg;
    logic [31:0] cur_ptr_reg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] desc_reg [0:3];
    logic [1:0] qidx_reg;
    logic [15:0] bytes_left_reg;
    logic [31:0] tx_data_reg;
    logic [2:0] tx_bytes_reg;
    logic tx_eop_reg;
    logic [3:0] ack_reg;
    logic irq_reg;
    logic [15:0] stamp_reg;
    logic apb_wr;
    logic apb_rd;
    logic addr_hit;
    logic [15:0] ccr_low;
    logic [3:0] f_cmd;
    logic [2:0] f_key;
    logic [1:0] f_int;
    logic f_status;
    logic [15:0] f_count;
    logic [3:0] f_z;
    logic is_imm;
    logic is_last;
    logic expired;
    logic irq_fire;
    logic push_done;
    logic [15:0] take;

    // ----------
    // descriptor field decode
    // ----------
    assign f_cmd = desc_reg[0][ATXD_CMD_LO +: 4];
    assign f_key = desc_reg[0][ATXD_KEY_LO +: 3];
    assign f_int = desc_reg[0][ATXD_INT_LO +: 2];
    assign f_status = desc_reg[0][ATXD_S_BIT];
    assign f_count = desc_reg[0][15:0];
    assign f_z = desc_reg[2][3:0];
    // both fields must match, so the two types can never alias
    assign is_imm = (f_cmd == ATXD_OP_MORE)
        && (f_key == ATXD_KEY_IMM);
    assign is_last = (f_cmd == ATXD_OP_LAST)
        && (f_key == ATXD_KEY_BUF);

    // deadline compare on the live cycle timer
    atxd_deadline_chk u_deadline (
        .now_seconds(cycle_seconds_count[2:0]),
        .now_ticks(cycle_tick_count),
        .deadline(desc_reg[3][15:0]),
        .expired(expired)
    );

    // interrupt decision for the final descriptor
    atxd_irq_sel u_irq (
        .int_field(f_int),
        .ack_code(ack_reg),
        .fire(irq_fire)
    );

    // ----------
    // apb slave
    // ----------
    // zero wait states; a frozen block holds the transfer via pready
    assign pready = ce;
    assign apb_wr = psel & penable & pwrite & ce;
    assign apb_rd = psel & penable & ~pwrite & ce;
    assign addr_hit = (paddr == ATXD_OFF_CTRL) || (paddr == ATXD_OFF_PTR)
        || (paddr == ATXD_OFF_STATUS) || (paddr == ATXD_OFF_CUR);
    assign pslverr = psel & penable & ~addr_hit;
    assign ccr_low = {run_reg, 3'h0, dead_reg, ~state_reg[0], missed_reg,
        5'h00, 4'(ack_reg)};

    // read mux; unmapped reads return zero with an error
    always_comb begin
        prdata = 32'h0000_0000;
        if (apb_rd) begin
            case (paddr)
                ATXD_OFF_CTRL: prdata = {30'h0000_0000, resp_reg, run_reg};
                ATXD_OFF_PTR: prdata = ptr_reg;
                ATXD_OFF_STATUS: prdata = {16'h0000, ccr_low};
                ATXD_OFF_CUR: prdata = cur_ptr_reg;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    // software steer bits; hardware stops the run at list end or fault
    always_ff @(posedge mclk) begin
        if (srst) begin
            run_reg <= 1'b0;
            resp_reg <= 1'b0;
            ptr_reg <= ATXD_RST_PTR;
        end else if (ce) begin
            if (apb_wr && paddr == ATXD_OFF_CTRL) begin
                run_reg <= pwdata[ATXD_CTRL_RUN];
                resp_reg <= pwdata[ATXD_CTRL_RESP];
            end else if (state_reg == ATXD_ST_HALT) begin
                run_reg <= 1'b0;
            end else if (state_reg == ATXD_ST_NEXT && is_last
                && f_z == 4'h0) begin
                run_reg <= 1'b0;
            end
            // pointer only takes a write while the engine is stopped
            if (apb_wr && paddr == ATXD_OFF_PTR && state_reg == ATXD_ST_IDLE)
            begin
                ptr_reg <= {pwdata[31:4], 4'h0};
            end
        end
    end

    // sticky faults: hardware set wins over a software clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            dead_reg <= 1'b0;
            missed_reg <= 1'b0;
        end else if (ce) begin
            if (state_reg == ATXD_ST_DECODE && !is_imm && !is_last) begin
                dead_reg <= 1'b1;
            end else if (apb_wr && paddr == ATXD_OFF_STATUS
                && pwdata[ATXD_CCR_DEAD]) begin
                dead_reg <= 1'b0;
            end
            if (state_reg == ATXD_ST_DECODE && is_imm && resp_reg && expired)
            begin
                missed_reg <= 1'b1;
            end else if (apb_wr && paddr == ATXD_OFF_STATUS
                && pwdata[ATXD_CCR_MISSED]) begin
                missed_reg <= 1'b0;
            end
        end
    end

    // ----------
    // controller state machine
    // ----------
    assign push_done = tx_ready | drop_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ATXD_ST_IDLE: begin
                if (run_reg) begin
                    state_next = ATXD_ST_FETCH;
                end
            end
            ATXD_ST_FETCH: begin
                if (mem_ack && qidx_reg == 2'd3) begin
                    state_next = ATXD_ST_DECODE;
                end
            end
            ATXD_ST_DECODE: begin
                if (is_imm) begin
                    state_next = ATXD_ST_READ;
                end else if (is_last) begin
                    // an empty buffer still closes the packet
                    state_next = (f_count == 16'h0000) ? ATXD_ST_PUSH
                        : ATXD_ST_READ;
                end else begin
                    state_next = ATXD_ST_HALT;
                end
            end
            ATXD_ST_READ: begin
                if (mem_ack) begin
                    state_next = ATXD_ST_PUSH;
                end
            end
            ATXD_ST_PUSH: begin
                if (push_done) begin
                    if (bytes_left_reg != 16'h0000) begin
                        state_next = ATXD_ST_READ;
                    end else if (is_imm) begin
                        state_next = ATXD_ST_NEXT;
                    end else if (drop_reg) begin
                        // nothing went out, so no ack will come
                        state_next = f_status ? ATXD_ST_WBACK : ATXD_ST_NEXT;
                    end else begin
                        state_next = ATXD_ST_ACK;
                    end
                end
            end
            ATXD_ST_ACK: begin
                if (ack_valid) begin
                    state_next = f_status ? ATXD_ST_WBACK
                        : ATXD_ST_NEXT;
                end
            end
            ATXD_ST_WBACK: begin
                if (mem_ack) begin
                    state_next = ATXD_ST_NEXT;
                end
            end
            ATXD_ST_NEXT: begin
                state_next = (is_last && f_z == 4'h0) ? ATXD_ST_IDLE
                    : ATXD_ST_FETCH;
            end
            ATXD_ST_HALT: begin
                state_next = ATXD_ST_IDLE;
            end
            default: begin
                state_next = ATXD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_reg <= ATXD_ST_IDLE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // ----------
    // descriptor pointer, memory address and fetch index
    // ----------
    always_ff @(posedge mclk) begin
        if (srst) begin
            cur_ptr_reg <= ATXD_RST_PTR;
            addr_reg <= ATXD_RST_PTR;
            qidx_reg <= 2'd0;
        end else if (ce) begin
            case (state_reg)
                ATXD_ST_IDLE: begin
                    cur_ptr_reg <= ptr_reg;
                    addr_reg <= ptr_reg;
                    qidx_reg <= 2'd0;
                end
                ATXD_ST_FETCH, ATXD_ST_READ: begin
                    if (mem_ack) begin
                        addr_reg <= addr_reg + 32'h0000_0004;
                        qidx_reg <= qidx_reg + 2'd1;
                    end
                end
                ATXD_ST_DECODE: begin
                    // inline quadlets sit right after the first 16 bytes
                    addr_reg <= is_imm ? cur_ptr_reg + ATXD_IMM_DATA_OFF
                        : desc_reg[1];
                end
                ATXD_ST_PUSH: begin
                    if (push_done && bytes_left_reg == 16'h0000
                        && !is_imm) begin
                        addr_reg <= cur_ptr_reg + ATXD_STATUS_Q_OFF;
                    end
                end
                ATXD_ST_NEXT: begin
                    qidx_reg <= 2'd0;
                    if (is_imm) begin
                        cur_ptr_reg <= cur_ptr_reg + ATXD_IMM_DESC_SIZE;
                        addr_reg <= cur_ptr_reg + ATXD_IMM_DESC_SIZE;
                    end else begin
                        cur_ptr_reg <= {desc_reg[2][31:4], 4'h0};
                        addr_reg <= {desc_reg[2][31:4], 4'h0};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // descriptor quadlet store, one word per fetch answer
    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < 4; i++) begin
                desc_reg[i] <= 32'h0000_0000;
            end
        end else if (ce) begin
            if (state_reg == ATXD_ST_FETCH && mem_ack) begin
                desc_reg[qidx_reg] <= mem_rdata;
            end
        end
    end

    // ----------
    // byte accounting and transmit word
    // ----------
    assign take = (bytes_left_reg > 16'h0004) ? 16'h0004 : bytes_left_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            bytes_left_reg <= 16'h0000;
            tx_data_reg <= 32'h0000_0000;
            tx_bytes_reg <= 3'd0;
            tx_eop_reg <= 1'b0;
        end else if (ce) begin
            if (state_reg == ATXD_ST_DECODE) begin
                // clamp so a header never exceeds four quadlets
                bytes_left_reg <= (is_imm && f_count > ATXD_IMM_MAX_BYTES)
                    ? ATXD_IMM_MAX_BYTES : f_count;
                tx_data_reg <= 32'h0000_0000;
                tx_bytes_reg <= 3'd0;
                tx_eop_reg <= is_last;
            end else if (state_reg == ATXD_ST_READ && mem_ack) begin
                tx_data_reg <= mem_rdata;
                tx_bytes_reg <= take[2:0];
                bytes_left_reg <= bytes_left_reg - take;
                // end of packet rides on the last buffer word
                tx_eop_reg <= is_last && (bytes_left_reg == take);
            end
        end
    end

    // late response packets are walked but never handed to the fifo
    always_ff @(posedge mclk) begin
        if (srst) begin
            drop_reg <= 1'b0;
        end else if (ce) begin
            if (state_reg == ATXD_ST_DECODE && is_imm) begin
                drop_reg <= resp_reg && expired;
            end else if (state_reg == ATXD_ST_NEXT && is_last) begin
                drop_reg <= 1'b0;
            end
        end
    end

    assign tx_valid = state_reg[4] & ~drop_reg;
    assign tx_data = tx_data_reg;
    assign tx_bytes = tx_bytes_reg;
    assign tx_eop = tx_eop_reg;

    // ----------
    // acknowledge, status write-back and interrupt
    // ----------
    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_reg <= ATXD_ACK_NONE;
            stamp_reg <= 16'h0000;
        end else if (ce) begin
            if (state_reg == ATXD_ST_DECODE && is_last) begin
                ack_reg <= ATXD_ACK_NONE;
            end else if (state_reg == ATXD_ST_ACK && ack_valid) begin
                ack_reg <= ack_code;
            end
            // capture completion time as seconds[2:0] then ticks
            if (state_reg == ATXD_ST_PUSH && push_done
                && bytes_left_reg == 16'h0000) begin
                stamp_reg <= {cycle_seconds_count[2:0],
                    cycle_tick_count};
            end
        end
    end

    // status word frozen while the write is outstanding; the fresh ack
    // is folded in at its own edge so the write never carries a stale one
    always_ff @(posedge mclk) begin
        if (srst) begin
            wdata_reg <= 32'h0000_0000;
        end else if (ce && state_reg != ATXD_ST_WBACK) begin
            wdata_reg <= {ccr_low[15:4], (state_reg == ATXD_ST_ACK
                && ack_valid) ? ack_code : ack_reg, stamp_reg};
        end
    end

    assign mem_req = state_reg[1] | state_reg[3] | state_reg[6];
    assign mem_we = state_reg[6];
    assign mem_addr = addr_reg;
    assign mem_wdata = wdata_reg;

    // one-cycle completion pulse at the end of a final descriptor
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_reg <= 1'b0;
        end else if (ce) begin
            irq_reg <= (state_reg == ATXD_ST_NEXT) && is_last
                && irq_fire;
        end
    end

    assign context_irq = irq_reg;

endmodule // atxd_main
`default_nettype wire

// ---- verif/atxd_chk.sv ----
// assertion checker for the descriptor engine ports
`timescale 1ns/10ps
`default_nettype none
module atxd_chk (
    // clock, reset and register bus
    input wire logic mclk, srst, ce, psel, penable, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata, mem_addr, tx_data,
    // memory and fifo
    input wire logic mem_req, mem_we, mem_ack, tx_valid, tx_ready,
    input wire logic tx_eop, context_irq,
    input wire logic [2:0] tx_bytes
);
    // ----------
    // port relations
    // ----------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    property p_mem; mem_req && !mem_ack |=> $stable(mem_addr); endproperty
    a_mem: assert property (p_mem) else $error("address moved");
    property p_wb; mem_req && mem_we |-> mem_addr[3:0] == 4'hC; endproperty
    a_wb: assert property (p_wb) else $error("bad status slot");
    property p_tx; tx_valid && !tx_ready |=> $stable(tx_data); endproperty
    a_tx: assert property (p_tx) else $error("fifo word moved");
    property p_byt; tx_valid |-> tx_bytes <= 3'd4; endproperty
    a_byt: assert property (p_byt) else $error("too many bytes");
    // after the closing word the engine waits for the acknowledge
    property p_eop; tx_valid && tx_ready && tx_eop && ce |=> !tx_valid;
    endproperty
    a_eop: assert property (p_eop) else $error("word after end");
    property p_irq; context_irq && ce |=> !context_irq; endproperty
    a_irq: assert property (p_irq) else $error("irq not a pulse");
    property p_ex; mem_req |-> !tx_valid; endproperty
    a_ex: assert property (p_ex) else $error("push during fetch");
    property p_bad; psel && penable && paddr[11:4] != 0 |-> pslverr
        && prdata == 32'h0000_0000; endproperty
    a_bad: assert property (p_bad) else $error("unmapped accepted");
    c_eop: cover property (tx_valid && tx_ready && tx_eop);
    c_wb: cover property (mem_req && mem_we && mem_ack);
    c_irq: cover property (context_irq);
endmodule // atxd_chk
`default_nettype wire

// ---- verif/atxd_far_model.sv ----
// host memory and transmit fifo stand-in for the descriptor engine
`timescale 1ns/10ps
`default_nettype none
module atxd_far_model (
    // clock, reset and pacing
    input wire logic mclk, srst, slow,
    // host memory port
    input wire logic mem_req, mem_we,
    input wire logic [31:0] mem_addr, mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // transmit fifo port
    input wire logic tx_valid, tx_eop,
    input wire logic [31:0] tx_data,
    output logic tx_ready
);
    logic [31:0] mem [0:63];
    logic [31:0] got[$];
    logic [1:0] wait_cnt;
    int eop_cnt;
    // released read data keeps changing so a late sample cannot match;
    // slow mode stalls memory three cycles and the fifo every other one
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
            eop_cnt <= eop_cnt + int'(tx_eop);
        end
        if (srst || !mem_req || mem_ack)
            wait_cnt <= slow ? 2'd3 : 2'd0;
        else if (wait_cnt != 2'd0)
            wait_cnt <= wait_cnt - 2'd1;
        else begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:2]];
            if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
        end
        if (srst) tx_ready <= 1'b0;
    end
endmodule // atxd_far_model
`default_nettype wire

// ---- verif/tb_async_tx_descriptor_decode.sv ----
// self-checking bench for the async transmit descriptor engine
`timescale 1ns/10ps
`default_nettype none
module tb_async_tx_descriptor_decode;
    logic mclk, srst, ce, psel, penable, pwrite, pready, pslverr, slow;
    logic mem_req, mem_we, mem_ack, ack_valid, tx_valid, tx_ready, tx_eop;
    logic context_irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, tx_data;
    logic [6:0] cycle_seconds_count;
    logic [12:0] cycle_tick_count;
    logic [3:0] ack_code;
    logic [2:0] tx_bytes;
    int num_errors, checks, irq_cnt, cycles;
    atxd_main dut (.mclk, .srst, .ce, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .cycle_seconds_count,
        .cycle_tick_count, .ack_valid, .ack_code, .tx_valid, .tx_ready,
        .tx_data, .tx_bytes, .tx_eop, .context_irq);
    atxd_far_model far (.mclk, .srst, .slow, .mem_req, .mem_we, .mem_addr,
        .mem_wdata, .mem_ack, .mem_rdata, .tx_valid, .tx_eop, .tx_data,
        .tx_ready);
    // ----------
    // helpers
    // ----------
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // header-immediate at 0x00, final-buffer at 0x20 with six bytes at 0x40
    task automatic run_pkt(input logic [15:0] hcnt, input logic s,
            input logic [1:0] isel, input logic [3:0] ack, input logic resp);
        logic [31:0] r;
        int e0;
        far.mem[0] = {16'h0200, hcnt};
        far.mem[3] = 32'h0000_0000;
        for (int k = 0; k < 4; k++) far.mem[4 + k] = 32'hA000_0000 + k;
        far.mem[8] = {4'h1, s, 3'h0, 2'b00, isel, 4'hC, 16'h0006};
        far.mem[9] = 32'h0000_0040;
        far.mem[10] = 32'h0000_0000;
        far.mem[11] = 32'hFFFF_FFFF;
        far.mem[16] = 32'hB000_0001;
        far.mem[17] = 32'hB000_0002;
        far.got.delete();
        irq_cnt = 0;
        e0 = far.eop_cnt;
        apb(1'b1, 12'h004, 32'h0000_0000, r);
        apb(1'b1, 12'h000, {30'h0, resp, 1'b1}, r);
        if (!resp) begin
            for (int n = 0; n < 400 && far.eop_cnt == e0; n++) @(posedge mclk);
            ack_valid <= 1'b1;
            ack_code <= ack;
            @(posedge mclk);
            ack_valid <= 1'b0;
        end
        r = 32'h0000_0001;
        for (int n = 0; n < 60 && r[0]; n++) apb(1'b0, 12'h000, 32'h0, r);
        repeat (3) @(posedge mclk); // let the irq pulse be counted
    endtask
    task automatic chk_words(input int n);
        check("count", 32'(far.got.size()), 32'(n + 2));
        for (int k = 0; k < n; k++)
            check("header", far.got[k], 32'hA000_0000 + k);
        check("tail", far.got[n + 1], 32'hB000_0002);
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_plain();
        slow <= 1'b1;
        run_pkt(16'h0010, 1'b1, 2'b11, 4'h1, 1'b0);
        chk_words(4);
        check("irq", 32'(irq_cnt), 32'd1);
        check("stamp", {16'h0, far.mem[11][15:0]},
            {16'h0, cycle_seconds_count[2:0], cycle_tick_count});
        check("status", {28'h0, far.mem[11][19:16]}, 32'h1);
        slow <= 1'b0;
        $display("t_plain done");
    endtask
    task automatic t_irq();
        run_pkt(16'h0008, 1'b0, 2'b01, 4'h1, 1'b0);
        chk_words(2);
        check("no wback", far.mem[11], 32'hFFFF_FFFF);
        check("irq ok ack", 32'(irq_cnt), 32'd0);
        run_pkt(16'h0008, 1'b0, 2'b01, 4'h4, 1'b0);
        check("irq bad ack", 32'(irq_cnt), 32'd1);
        run_pkt(16'h0008, 1'b0, 2'b00, 4'h4, 1'b0);
        check("irq never", 32'(irq_cnt), 32'd0);
        $display("t_irq done");
    endtask
    // deadline 0 lies one second and 0x123 ticks behind the timer
    task automatic t_late();
        logic [31:0] r;
        run_pkt(16'h0008, 1'b0, 2'b00, 4'h1, 1'b1);
        check("dropped", 32'(far.got.size()), 32'd0);
        apb(1'b0, 12'h008, 32'h0, r);
        check("missed", {31'h0, r[9]}, 32'h1);
        apb(1'b0, 12'h010, 32'h0, r);
        check("unmapped", r, 32'h0000_0000);
        $display("t_late done");
    endtask
    // ----------
    // clock, timeout and main sequence
    // ----------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (context_irq === 1'b1) irq_cnt++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        {srst, ce, psel, penable, pwrite, slow, ack_valid} = 7'b1100000;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        ack_code = 4'h0;
        cycle_seconds_count = 7'd9;
        cycle_tick_count = 13'h0123;
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        t_plain();
        t_irq();
        t_late();
        conclude();
    end
endmodule // tb_async_tx_descriptor_decode
bind atxd_main atxd_chk chk (.mclk, .srst, .ce, .psel, .penable,
    .pslverr, .paddr, .prdata, .mem_addr, .tx_data, .mem_req, .mem_we,
    .mem_ack, .tx_valid, .tx_ready, .tx_eop, .context_irq, .tx_bytes);
`default_nettype wire
